/* logic/flash_adc_encode_pipeline.v */
// digital back end of an 8-bit flash converter: thermometer to demuxed gray output
// assumes comparator bits arrive synchronous to clock; no reset on the data path ahead of the output banks
`include "flash_enc_defs.vh"
module flash_adc_encode_pipeline (
   // clock and reset
   input wire clock,
   input wire rst,
   // comparator results, bit k set when input is above level k
   input wire [255:0] comparator_bits,
   // overrange comparator, above top plus half step
   input wire overrange_cmp,
   // bank a
   output reg [7:0] result_bits_bank_a,
   output reg overrange_flag_a,
   output wire sample_valid_strobe_a,
   output wire sample_valid_strobe_a_n,
   // bank b
   output reg [7:0] result_bits_bank_b,
   output reg overrange_flag_b,
   output wire sample_valid_strobe_b,
   output wire sample_valid_strobe_b_n
);

   // sampling stage
   reg [255:0] therm_ff;
   reg over_ff;

   // decoder input stage
   reg [255:0] col_in_ff;
   reg col_over_ff;

   // column latch stage: four 7-bit words side by side
   reg [27:0] col_latch_ff;
   // overrange travels with the latched columns, one stage per stage
   reg latch_over_ff;

   // pipeline control
   reg col_valid_ff;
   reg bank_sel_ff;
   reg dr_a_ff;
   reg dr_b_ff;
   reg nxt_col_valid;
   reg nxt_bank_sel;
   reg nxt_dr_a;
   reg nxt_dr_b;

   // decoder outputs
   wire [23:0] col_count;
   wire [3:0] col_full;
   wire [27:0] col_word;

   // merge and encode
   reg [1:0] sel_col;
   reg [5:0] sel_lsb;
   wire [7:0] bin_code;
   wire [7:0] gray_code;
   wire all_full;
   wire all_empty;
   reg [7:0] nxt_code;
   reg nxt_over;

   // next values of the output banks
   reg [7:0] nxt_result_a;
   reg nxt_over_a;
   reg [7:0] nxt_result_b;
   reg nxt_over_b;

   // freeze tracked comparator bits at the sampling edge
   always @(posedge clock) begin
      therm_ff <= comparator_bits;
   end

   always @(posedge clock) begin
      over_ff <= overrange_cmp;
   end

   // decoder input register; the falling half-cycle is folded into this edge
   always @(posedge clock) begin
      col_in_ff <= therm_ff;
   end

   always @(posedge clock) begin
      col_over_ff <= over_ff;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : cols
         col_decoder u_col_decoder (
            .therm(col_in_ff[g*64 +: 64]),
            .count(col_count[g*6 +: 6]),
            .full(col_full[g])
         );
         // 7-bit word: column-full flag above the count
         assign col_word[g*7 +: 7] = {col_full[g], col_count[g*6 +: 6]};
      end
   endgenerate

   // one latch for all columns keeps a single driver on the word
   always @(posedge clock) begin
      col_latch_ff <= col_word;
   end

   // without this stage the flag would run one sample ahead of the code
   always @(posedge clock) begin
      latch_over_ff <= col_over_ff;
   end

   // pick the topmost column whose lower neighbour is full
   always @* begin
      if (col_latch_ff[20]) begin
         sel_col = 2'h3;
         sel_lsb = col_latch_ff[26:21];
      end else if (col_latch_ff[13]) begin
         sel_col = 2'h2;
         sel_lsb = col_latch_ff[19:14];
      end else if (col_latch_ff[6]) begin
         sel_col = 2'h1;
         sel_lsb = col_latch_ff[12:7];
      end else begin
         sel_col = 2'h0;
         sel_lsb = col_latch_ff[5:0];
      end
   end

   assign bin_code = {sel_col, sel_lsb};

   // reflected binary, one exclusive-or per bit pair
   generate
      for (g = 0; g < 7; g = g + 1) begin : gray_bits
         assign gray_code[g] = bin_code[g] ^ bin_code[g+1];
      end
   endgenerate

   assign gray_code[7] = bin_code[7];

   // all 256 levels set, or none set at all
   assign all_full = col_latch_ff[27];
   assign all_empty = ~col_latch_ff[6] & (col_latch_ff[5:0] == 6'h00);

   always @* begin
      if (all_full && latch_over_ff) begin
         nxt_code = `OVERRANGE_CODE;
         nxt_over = 1'b1;
      end else if (all_empty) begin
         nxt_code = `ZERO_CODE;
         nxt_over = 1'b0;
      end else begin
         nxt_code = gray_code;
         nxt_over = 1'b0;
      end
   end

   // valid rises at the first edge after reset, without waiting for the pipeline to fill
   always @* begin
      nxt_col_valid = 1'b1;
      nxt_bank_sel = bank_sel_ff;
      nxt_dr_a = 1'b0;
      nxt_dr_b = 1'b0;
      if (col_valid_ff) begin
         nxt_bank_sel = ~bank_sel_ff;
         nxt_dr_a = ~bank_sel_ff;
         nxt_dr_b = bank_sel_ff;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         col_valid_ff <= 1'b0;
         bank_sel_ff <= 1'b0;
      end else begin
         col_valid_ff <= nxt_col_valid;
         bank_sel_ff <= nxt_bank_sel;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         dr_a_ff <= 1'b0;
         dr_b_ff <= 1'b0;
      end else begin
         dr_a_ff <= nxt_dr_a;
         dr_b_ff <= nxt_dr_b;
      end
   end

   // output latches; a bank holds while the other updates
   always @* begin
      nxt_result_a = result_bits_bank_a;
      nxt_over_a = overrange_flag_a;
      if (col_valid_ff && !bank_sel_ff) begin
         nxt_result_a = nxt_code;
         nxt_over_a = nxt_over;
      end
   end

   always @* begin
      nxt_result_b = result_bits_bank_b;
      nxt_over_b = overrange_flag_b;
      if (col_valid_ff && bank_sel_ff) begin
         nxt_result_b = nxt_code;
         nxt_over_b = nxt_over;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         result_bits_bank_a <= 8'h00;
         overrange_flag_a <= 1'b0;
      end else begin
         result_bits_bank_a <= nxt_result_a;
         overrange_flag_a <= nxt_over_a;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         result_bits_bank_b <= 8'h00;
         overrange_flag_b <= 1'b0;
      end else begin
         result_bits_bank_b <= nxt_result_b;
         overrange_flag_b <= nxt_over_b;
      end
   end

   // both polarities come from one flop, so the pair never skews apart
   assign sample_valid_strobe_a = dr_a_ff;
   assign sample_valid_strobe_a_n = ~dr_a_ff;
   assign sample_valid_strobe_b = dr_b_ff;
   assign sample_valid_strobe_b_n = ~dr_b_ff;
endmodule

/* logic/flash_enc_defs.vh */
// constants for the flash converter encode pipeline
// assumes a single clock; no registers reachable by software
`ifndef FLASH_ENC_DEFS_VH
`define FLASH_ENC_DEFS_VH
`define NUM_LEVELS 256
`define NUM_COLS 4
`define COL_WIDTH 64
`define LSB_WIDTH 6
`define MSB_WIDTH 2
`define RESULT_WIDTH 8
`define COL_LATCH_WIDTH 7
`define OVERRANGE_CODE 8'h80
`define ZERO_CODE 8'h00
`endif

/* logic/col_decoder.v */
// one 64-to-6 thermometer column decoder
// assumes a thermometer input, ones from bit 0 upward; bubbles are tolerated
module col_decoder (
   // thermometer column
   input wire [63:0] therm,
   // highest set bit of bits 0 to 62, plus one, and a column-full flag
   output reg [5:0] count,
   output reg full
);
   integer i;
   always @* begin
      count = 6'h00;
      full = therm[63];
      // highest set bit wins, so a stray low bubble cannot lower the code
      for (i = 0; i < 63; i = i + 1) begin
         if (therm[i]) begin
            count = i[5:0] + 6'h01;
         end
      end
   end
endmodule

/* dv/flash_enc_chk_assertions.sv */
// checker for the encode pipeline outputs
// assumes rst is high for the first cycles
module flash_enc_chk (
   input wire logic clock, rst, overrange_cmp, overrange_flag_a, overrange_flag_b,
   input wire logic sample_valid_strobe_a, sample_valid_strobe_a_n,
   input wire logic sample_valid_strobe_b, sample_valid_strobe_b_n,
   input wire logic [255:0] comparator_bits,
   input wire logic [7:0] result_bits_bank_a, result_bits_bank_b
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_ia; sample_valid_strobe_a_n != sample_valid_strobe_a; endproperty
   a_ia: assert property (p_ia) else $error("strobe a pair equal");
   property p_ib; sample_valid_strobe_b_n != sample_valid_strobe_b; endproperty
   a_ib: assert property (p_ib) else $error("strobe b pair equal");
   property p_ab; sample_valid_strobe_a |=> sample_valid_strobe_b; endproperty
   a_ab: assert property (p_ab) else $error("bank b missed");
   property p_ba; sample_valid_strobe_b |=> sample_valid_strobe_a; endproperty
   a_ba: assert property (p_ba) else $error("bank a missed");
   property p_oa; overrange_flag_a |-> result_bits_bank_a == 8'h80; endproperty
   a_oa: assert property (p_oa) else $error("bad overrange a");
   property p_ob; overrange_flag_b |-> result_bits_bank_b == 8'h80; endproperty
   a_ob: assert property (p_ob) else $error("bad overrange b");
   property p_ha; $changed(result_bits_bank_a) |-> sample_valid_strobe_a; endproperty
   a_ha: assert property (p_ha) else $error("bank a moved");
   property p_hb; $changed(result_bits_bank_b) |-> sample_valid_strobe_b; endproperty
   a_hb: assert property (p_hb) else $error("bank b moved");
endmodule
bind flash_adc_encode_pipeline flash_enc_chk u_chk (.*);

/* dv/capture_model.sv */
// capture logic: keeps the latest sample of either bank
// assumes strobes arrive with their bank data
module capture_model (
   input wire logic clock, stb_a, stb_b,
   input wire logic [8:0] word_a, word_b,
   output logic [8:0] last_ff
);
   always @(posedge clock) begin
      if (stb_a) last_ff <= word_a;
      else if (stb_b) last_ff <= word_b;
   end
endmodule

/* dv/flash_adc_encode_pipeline_tb_top.sv */
// bench: every level, then overrange
// assumes capture_model and the bound checker
module flash_adc_encode_pipeline_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst = 1, ovr = 0;
   logic [255:0] bits = '0;
   wire [8:0] a, b, cap;
   wire sa, sb;
   int n_fail = 0, num_checks = 0, cyc = 0;
   flash_adc_encode_pipeline u_flash_adc_encode_pipeline (.clock(clock), .rst(rst),
      .comparator_bits(bits), .overrange_cmp(ovr), .result_bits_bank_a(a[7:0]),
      .overrange_flag_a(a[8]), .sample_valid_strobe_a(sa), .sample_valid_strobe_a_n(),
      .result_bits_bank_b(b[7:0]), .overrange_flag_b(b[8]), .sample_valid_strobe_b(sb),
      .sample_valid_strobe_b_n());
   capture_model u_capture_model (.clock(clock), .stb_a(sa), .stb_b(sb), .word_a(a),
      .word_b(b), .last_ff(cap));
   initial forever #2 clock = ~clock;
   always @(posedge clock) if (++cyc == 3000) print_verdict(1);
   task check(logic [8:0] seen, logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // level held long enough that both banks carry it
   task s_sweep;
      for (int n = 0; n < 257; n++) begin
         bits = n > 255 ? '1 : (256'h1 << n) - 256'h1;
         ovr = n > 255;
         repeat (9) @(negedge clock);
         check(cap, n > 255 ? 9'h180 : 9'(n ^ (n >> 1)));
      end
   endtask
   // step down from overrange: the strobed bank turns over at the fourth edge
   task s_latency;
      bits = (256'h1 << 5) - 256'h1;
      ovr = 0;
      repeat (3) @(negedge clock);
      check(sa ? a : b, 9'h180);
      @(negedge clock);
      check(sa ? a : b, 9'h007);
   endtask
   task print_verdict(int late);
      n_fail += late;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clock);
      rst = 0;
      s_sweep();
      s_latency();
      print_verdict(0);
   end
endmodule
